// File: hdl/boost_pwm_map.svh
`ifndef BOOST_PWM_MAP_SVH
`define BOOST_PWM_MAP_SVH

// core clock rate
`define CLK_MHZ         250
`define CLK_KHZ         250000
// least time in ns to whole core cycles, rounded up
`define NS_TO_CYC(t)    ((((t) * `CLK_MHZ) + 999) / 1000)

// minimum on-time per code, ns
`define TON0_NS         100
`define TON1_NS         150
`define TON2_NS         200
`define TON3_NS         300

// minimum off-time per code, ns
`define TOFF0_NS        50
`define TOFF1_NS        100
`define TOFF2_NS        150
`define TOFF3_NS        200
`define TOFF4_NS        300
`define TOFF5_NS        400
`define TOFF6_NS        600
`define TOFF7_NS        800

// internal ticks without an external rising edge before failover
`define MISS_LIMIT      2'd3

// skip thresholds on the compensation level code
`define SKIP_THR0       8'h10
`define SKIP_THR1       8'h20
`define SKIP_THR2       8'h30
`define SKIP_THR3       8'h40

`endif

// File: hdl/boost_pwm_pkg.sv
`include "boost_pwm_map.svh"

package boost_pwm_pkg;

    // clock source select, decoded in this order
    typedef enum logic [1:0] {SRC_OFF, SRC_INT, SRC_EXT, SRC_AUTO} clk_src_e;

    typedef logic [15:0] cyc_t;

    // internal frequency table in kHz, indexed by the 5-bit code
    localparam logic [11:0] FREQ_KHZ [32] = '{
        12'd125, 12'd140, 12'd160, 12'd176, 12'd200, 12'd222, 12'd250, 12'd276,
        12'd302, 12'd333, 12'd381, 12'd444, 12'd500, 12'd552, 12'd593, 12'd667,
        12'd727, 12'd800, 12'd889, 12'd1000, 12'd1067, 12'd1143, 12'd1231,
        12'd1333, 12'd1455, 12'd1600, 12'd1778, 12'd2000, 12'd2286, 12'd2667,
        12'd3200, 12'd4000};

    // period of the internal clock in core cycles
    function automatic cyc_t int_period(input logic [4:0] code);
        return cyc_t'(`CLK_KHZ / int'(FREQ_KHZ[code]));
    endfunction : int_period

    function automatic cyc_t ton_cyc(input logic [1:0] code);
        case (code)
            2'd0:    return cyc_t'(`NS_TO_CYC(`TON0_NS));
            2'd1:    return cyc_t'(`NS_TO_CYC(`TON1_NS));
            2'd2:    return cyc_t'(`NS_TO_CYC(`TON2_NS));
            default: return cyc_t'(`NS_TO_CYC(`TON3_NS));
        endcase
    endfunction : ton_cyc

    function automatic cyc_t toff_cyc(input logic [2:0] code);
        case (code)
            3'd0:    return cyc_t'(`NS_TO_CYC(`TOFF0_NS));
            3'd1:    return cyc_t'(`NS_TO_CYC(`TOFF1_NS));
            3'd2:    return cyc_t'(`NS_TO_CYC(`TOFF2_NS));
            3'd3:    return cyc_t'(`NS_TO_CYC(`TOFF3_NS));
            3'd4:    return cyc_t'(`NS_TO_CYC(`TOFF4_NS));
            3'd5:    return cyc_t'(`NS_TO_CYC(`TOFF5_NS));
            3'd6:    return cyc_t'(`NS_TO_CYC(`TOFF6_NS));
            default: return cyc_t'(`NS_TO_CYC(`TOFF7_NS));
        endcase
    endfunction : toff_cyc

    // state of one gate driver
    typedef struct packed {
        logic on;
        cyc_t cnt;
    } gate_s;

    // state of the clock and sequencing logic
    typedef struct packed {
        logic       sync_a;
        logic       sync_b;
        logic       sync_c;
        logic [1:0] trip_a;
        logic [1:0] trip_b;
        cyc_t       int_cnt;
        logic       int_tick;
        logic [1:0] miss;
        logic       use_int;
        logic       half;
        logic       phase;
        cyc_t       per_cnt;
        cyc_t       tick_per;
        logic [1:0] start;
        logic       fail;
        logic       skip;
    } pwm_s;

endpackage : boost_pwm_pkg

// File: hdl/boost_gate_phase.sv
`timescale 1ns/100ps
`default_nettype none

module boost_gate_phase
    import boost_pwm_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    // cycle control
    input  wire logic i_start,
    input  wire logic i_enable,
    input  wire logic i_skip,
    input  wire logic i_trip,
    // timing limits in core cycles
    input  wire cyc_t i_period,
    input  wire cyc_t i_min_on,
    input  wire cyc_t i_min_off,
    // gate drive
    output logic      o_gate
);

    gate_s q;
    gate_s d;
    cyc_t  max_on;

    // longest on-time that still leaves the minimum off-time
    assign max_on = (i_period > i_min_off) ? (i_period - i_min_off) : '0;

    // pulse sequencing
    always_comb begin
        d = q;
        if (q.on) begin
            if ((i_trip && q.cnt >= i_min_on) || q.cnt >= max_on) begin
                d.on = 1'b0;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end else if (i_start && i_enable && !i_skip && !i_trip
                     && max_on >= i_min_on) begin
            d.on  = 1'b1;
            d.cnt = 16'h0001;
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '0;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_gate = q.on;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_min_on_hold: assert property (
        (i_ce && q.on && q.cnt < i_min_on && q.cnt < max_on) |=> q.on)
        else $error("gate released before minimum on-time");
    a_max_on_cut: assert property (
        (i_ce && q.on && q.cnt >= max_on) |=> !q.on)
        else $error("gate held into minimum off-time");
    a_skip_quiet: assert property (
        (i_ce && i_skip && !q.on) |=> !q.on)
        else $error("pulse issued while skipping");
    a_no_duty_off: assert property (
        (i_ce && i_start && i_trip && !q.on) |=> !q.on)
        else $error("pulse issued with no duty needed");
    c_gate_pulse: cover property ($fell(q.on));

endmodule : boost_gate_phase

`default_nettype wire

// File: hdl/boost_pwm_clock.sv
// Functional notes
// - five-bit code picks internal frequency table
// - source two takes frequency from sync pin
// - invert bit selects rising or falling sync
// - select decodes off, internal, external, auto
// - auto falls back after three missed edges
// - auto returns to external on rising edge
// - enabled phase with source off flags failure
// - external modes flag three missed edges
// - internal clock always runs for monitoring
// - gate pulse lasts at least minimum on-time
// - on-time codes map 100 to 300 ns
// - off-time codes map 50 to 800 ns
// - each period keeps minimum off-time
// - low compensation level stops pulses
// - internal rate derived from core clock
// - halving bit divides gate clock by two
// - shared clock gives each phase half rate
`timescale 1ns/100ps
`default_nettype none

module boost_pwm_clock
    import boost_pwm_pkg::*;
#(
    parameter int NPH = 2
) (
    // clock and reset
    input  wire logic             I_CLK,
    input  wire logic             I_RST,
    input  wire logic             I_CE,
    // pins from outside the clock domain
    input  wire logic             I_SYNC_PIN,
    input  wire logic [NPH-1:0]   I_CURRENT_TRIP,
    // configuration
    input  wire logic [1:0]       I_PWM_CLOCK_SOURCE_SELECT,
    input  wire logic [4:0]       I_INTERNAL_PWM_FREQ_CODE,
    input  wire logic             I_SYNC_EDGE_INVERT,
    input  wire logic             I_GATE_CLOCK_HALVING,
    input  wire logic [NPH-1:0]   I_PHASE_ENABLE_BITS,
    input  wire logic [1:0]       I_MIN_ON_TIME_CODE,
    input  wire logic [2:0]       I_MIN_OFF_TIME_CODE,
    input  wire logic [1:0]       I_SKIP_THRESHOLD_CODE,
    // digitised compensation level
    input  wire logic [7:0]       I_COMPENSATION_VOLTAGE,
    // gate drive and status
    output logic      [NPH-1:0]   O_GATE,
    output logic                  O_SYNC_FAILURE_FLAG,
    output logic                  O_INTERNAL_CLOCK_ACTIVE,
    output logic                  O_SKIP_ACTIVE
);

    pwm_s     q;
    pwm_s     d;
    clk_src_e src;
    logic     ext_rise;
    logic     ext_fall;
    logic     ext_edge;
    logic     sel_tick;
    logic     gtick;
    cyc_t     per_int;
    cyc_t     phase_per;
    cyc_t     min_on;
    cyc_t     min_off;
    logic [7:0] skip_thr;

    assign src = clk_src_e'(I_PWM_CLOCK_SOURCE_SELECT);

    // edges of the synchronised sync pin
    assign ext_rise = q.sync_b & ~q.sync_c;
    assign ext_fall = ~q.sync_b & q.sync_c;
    assign ext_edge = I_SYNC_EDGE_INVERT ? ext_fall : ext_rise;

    // timing limits from the codes
    assign per_int = int_period(I_INTERNAL_PWM_FREQ_CODE);
    assign min_on  = ton_cyc(I_MIN_ON_TIME_CODE);
    assign min_off = toff_cyc(I_MIN_OFF_TIME_CODE);

    // skip threshold per code
    always_comb begin
        case (I_SKIP_THRESHOLD_CODE)
            2'd0:    skip_thr = `SKIP_THR0;
            2'd1:    skip_thr = `SKIP_THR1;
            2'd2:    skip_thr = `SKIP_THR2;
            default: skip_thr = `SKIP_THR3;
        endcase
    end

    // source multiplexer
    always_comb begin
        case (src)
            SRC_OFF:  sel_tick = 1'b0;
            SRC_INT:  sel_tick = q.int_tick;
            SRC_EXT:  sel_tick = ext_edge;
            default:  sel_tick = q.use_int ? q.int_tick : ext_edge;
        endcase
    end

    // optional halving passes every second tick
    assign gtick = sel_tick && (!I_GATE_CLOCK_HALVING || q.half);

    // each phase sees two clock ticks per period
    assign phase_per = q.tick_per[15] ? 16'hffff : {q.tick_per[14:0], 1'b0};

    // next-state logic
    always_comb begin
        d = q;
        // pin synchronisers
        d.sync_a = I_SYNC_PIN;
        d.sync_b = q.sync_a;
        d.sync_c = q.sync_b;
        d.trip_a = I_CURRENT_TRIP;
        d.trip_b = q.trip_a;
        // free-running internal clock
        if (q.int_cnt >= per_int - 16'h0001) begin
            d.int_cnt  = '0;
            d.int_tick = 1'b1;
        end else begin
            d.int_cnt  = q.int_cnt + 16'h0001;
            d.int_tick = 1'b0;
        end
        // count internal ticks since the last external rising edge
        if (ext_rise) begin
            d.miss = '0;
        end else if (q.int_tick && q.miss != `MISS_LIMIT) begin
            d.miss = q.miss + 2'd1;
        end
        // automatic source choice, held clear in the fixed modes
        // so that a stale fallback never shows outside auto mode
        if (src != SRC_AUTO || ext_rise) begin
            d.use_int = 1'b0;
        end else if (q.miss == `MISS_LIMIT) begin
            d.use_int = 1'b1;
        end
        // halving toggle
        if (sel_tick) begin
            d.half = ~q.half;
        end
        // tick spacing measurement, saturating
        if (gtick) begin
            d.tick_per = q.per_cnt;
            d.per_cnt  = 16'h0001;
        end else if (q.per_cnt != 16'hffff) begin
            d.per_cnt = q.per_cnt + 16'h0001;
        end
        // alternate phase starts
        d.start = '0;
        if (gtick) begin
            d.start[q.phase] = 1'b1;
            d.phase          = ~q.phase;
        end
        // sync failure status
        d.fail = ((|I_PHASE_ENABLE_BITS) && src == SRC_OFF)
              || ((src == SRC_EXT || src == SRC_AUTO) && q.miss == `MISS_LIMIT);
        // skip-cycle comparison
        d.skip = I_COMPENSATION_VOLTAGE < skip_thr;
    end

    // state register
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            q <= '0;
        end else if (I_CE) begin
            q <= d;
        end
    end

    // per-phase gate drivers
    generate
        for (genvar i = 0; i < NPH; i++) begin : g_phase
            boost_gate_phase u_gate (
                .i_clk    (I_CLK),
                .i_rst    (I_RST),
                .i_ce     (I_CE),
                .i_start  (q.start[i]),
                .i_enable (I_PHASE_ENABLE_BITS[i] && src != SRC_OFF),
                .i_skip   (q.skip),
                .i_trip   (q.trip_b[i]),
                .i_period (phase_per),
                .i_min_on (min_on),
                .i_min_off(min_off),
                .o_gate   (O_GATE[i])
            );
        end
    endgenerate

    // status outputs
    assign O_SYNC_FAILURE_FLAG     = q.fail;
    assign O_INTERNAL_CLOCK_ACTIVE = q.use_int;
    assign O_SKIP_ACTIVE           = q.skip;

    // helper logic for checking the internal period and the phase order
    cyc_t gap_q;
    logic chg_q;
    logic seen_q;
    logic last_q;
    logic [4:0] code_q;

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            gap_q  <= '0;
            chg_q  <= 1'b1;
            seen_q <= 1'b0;
            last_q <= 1'b1;
            code_q <= '0;
        end else if (I_CE) begin
            code_q <= I_INTERNAL_PWM_FREQ_CODE;
            gap_q  <= q.int_tick ? 16'h0001 : gap_q + 16'h0001;
            if (q.int_tick) begin
                chg_q  <= 1'b0;
                seen_q <= 1'b1;
            end else if (code_q != I_INTERNAL_PWM_FREQ_CODE) begin
                chg_q <= 1'b1;
            end
            if (q.start[0]) begin
                last_q <= 1'b0;
            end else if (q.start[1]) begin
                last_q <= 1'b1;
            end
        end
    end

    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    a_int_period: assert property (
        (I_CE && q.int_tick && seen_q && !chg_q && code_q == I_INTERNAL_PWM_FREQ_CODE)
        |-> gap_q == per_int)
        else $error("internal period does not match frequency code");
    a_off_quiet: assert property (
        (I_CE && src == SRC_OFF) |=> q.start == 2'b00)
        else $error("phase started with source off");
    a_ext_follow: assert property (
        (I_CE && src == SRC_EXT && !I_GATE_CLOCK_HALVING && ext_edge) |=> |q.start)
        else $error("external edge not followed");
    a_ext_other_edge: assert property (
        (I_CE && src == SRC_EXT && (I_SYNC_EDGE_INVERT ? ext_rise : ext_fall))
        |=> q.start == 2'b00)
        else $error("gate synchronised to wrong edge");
    a_auto_to_int: assert property (
        (I_CE && src == SRC_AUTO && q.miss == `MISS_LIMIT && !ext_rise) |=> q.use_int)
        else $error("no fallback after missed edges");
    a_auto_to_ext: assert property (
        (I_CE && ext_rise) |=> !q.use_int ##1 (q.miss != `MISS_LIMIT))
        else $error("no return to external clock");
    a_fail_off: assert property (
        (I_CE && |I_PHASE_ENABLE_BITS && src == SRC_OFF) |=> q.fail)
        else $error("failure flag missing with source off");
    a_fail_miss: assert property (
        (I_CE && (src == SRC_EXT || src == SRC_AUTO) && q.miss == `MISS_LIMIT) |=> q.fail)
        else $error("failure flag missing after missed edges");
    a_phase_alt: assert property (
        q.start[1] |-> !last_q)
        else $error("phases not alternating");

    // source routing and halving
    a_int_follow: assert property (
        (I_CE && src == SRC_INT && !I_GATE_CLOCK_HALVING && q.int_tick) |=> |q.start)
        else $error("internal tick not followed");
    a_ext_only_pin: assert property (
        (I_CE && src == SRC_EXT && !ext_edge) |=> q.start == 2'b00)
        else $error("external mode started without pin edge");
    a_half_block: assert property (
        (I_CE && I_GATE_CLOCK_HALVING && sel_tick && !q.half) |=> q.start == 2'b00)
        else $error("halving passed an odd tick");
    a_half_pass: assert property (
        (I_CE && I_GATE_CLOCK_HALVING && sel_tick && q.half) |=> |q.start)
        else $error("halving dropped an even tick");

    // monitoring, failover and skip bookkeeping
    a_int_free: assert property (
        (I_CE && q.int_cnt < per_int - 16'h0001)
        |=> q.int_cnt == $past(q.int_cnt) + 16'h0001)
        else $error("internal clock counter stalled");
    a_miss_reset: assert property (
        (I_CE && ext_rise) |=> q.miss == 2'd0)
        else $error("missed-edge count not cleared");
    a_miss_count: assert property (
        (I_CE && !ext_rise && q.int_tick && q.miss != `MISS_LIMIT)
        |=> q.miss == $past(q.miss) + 2'd1)
        else $error("missed-edge count not advanced");
    a_auto_only: assert property (
        (I_CE && src != SRC_AUTO) |=> !q.use_int)
        else $error("internal choice shown outside auto mode");
    a_fail_int: assert property (
        (I_CE && src == SRC_INT) |=> !q.fail)
        else $error("failure flag set with internal source");
    a_skip_set: assert property (
        (I_CE && I_COMPENSATION_VOLTAGE < skip_thr) |=> q.skip)
        else $error("skip not raised below threshold");
    a_skip_clear: assert property (
        (I_CE && I_COMPENSATION_VOLTAGE >= skip_thr) |=> !q.skip)
        else $error("skip raised at or above threshold");

    c_auto_fallback: cover property (src == SRC_AUTO && $rose(q.use_int));
    c_both_gates: cover property (O_GATE == 2'b10 ##[1:200] O_GATE == 2'b01);
    c_sync_fail: cover property ($rose(q.fail));
    c_halved_start: cover property (I_GATE_CLOCK_HALVING && |q.start);

endmodule : boost_pwm_clock

`default_nettype wire

// File: bench/sync_source.sv
`timescale 1ns/100ps
`default_nettype none

module sync_source (
    // run control and half period in ns
    input  wire logic        i_run,
    input  wire logic [15:0] i_half_ns,
    // sync pin
    output logic             o_sync
);
    logic [15:0] half;

    // free square wave while running, held low while stopped
    initial begin
        o_sync = 1'b0;
        #1.3;
        forever begin
            if (i_run) begin
                half = (i_half_ns < 16'h007d) ? 16'h007d : i_half_ns;
                #(half);
                o_sync = i_run ? ~o_sync : 1'b0;
            end else begin
                o_sync = 1'b0;
                @(posedge i_run);
            end
        end
    end
endmodule : sync_source

`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "boost_pwm_map.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
    $display("Error %s expected %0d seen %0d", nm, ex, got); end end

module tb_top;
    logic       I_CLK, I_RST, I_CE, I_SYNC_PIN, I_SYNC_EDGE_INVERT, I_GATE_CLOCK_HALVING;
    logic [1:0] I_CURRENT_TRIP, I_PWM_CLOCK_SOURCE_SELECT, I_PHASE_ENABLE_BITS;
    logic [1:0] I_MIN_ON_TIME_CODE, I_SKIP_THRESHOLD_CODE, O_GATE;
    logic [4:0] I_INTERNAL_PWM_FREQ_CODE;
    logic [2:0] I_MIN_OFF_TIME_CODE;
    logic [7:0] I_COMPENSATION_VOLTAGE;
    logic       O_SYNC_FAILURE_FLAG, O_INTERNAL_CLOCK_ACTIVE, O_SKIP_ACTIVE, run;
    logic [15:0] half_ns;
    int         bad_count, checked, n, w, i;
    int         ton_ns [4] = '{100, 150, 200, 300};
    int         toff_ns [8] = '{50, 100, 150, 200, 300, 400, 600, 800};
    int         thr [4] = '{`SKIP_THR0, `SKIP_THR1, `SKIP_THR2, `SKIP_THR3};
    int         fcode [3] = '{19, 27, 31};
    int         fper [3] = '{250, 125, 62};

    // 250 MHz core clock
    initial begin
        I_CLK = 1'b0;
        forever #2 I_CLK = ~I_CLK;
    end

    sync_source partner (.i_run(run), .i_half_ns(half_ns), .o_sync(I_SYNC_PIN));

    boost_pwm_clock #(.NPH(2)) uut (
        .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_SYNC_PIN(I_SYNC_PIN),
        .I_CURRENT_TRIP(I_CURRENT_TRIP), .I_PWM_CLOCK_SOURCE_SELECT(I_PWM_CLOCK_SOURCE_SELECT),
        .I_INTERNAL_PWM_FREQ_CODE(I_INTERNAL_PWM_FREQ_CODE),
        .I_SYNC_EDGE_INVERT(I_SYNC_EDGE_INVERT), .I_GATE_CLOCK_HALVING(I_GATE_CLOCK_HALVING),
        .I_PHASE_ENABLE_BITS(I_PHASE_ENABLE_BITS), .I_MIN_ON_TIME_CODE(I_MIN_ON_TIME_CODE),
        .I_MIN_OFF_TIME_CODE(I_MIN_OFF_TIME_CODE), .I_SKIP_THRESHOLD_CODE(I_SKIP_THRESHOLD_CODE),
        .I_COMPENSATION_VOLTAGE(I_COMPENSATION_VOLTAGE), .O_GATE(O_GATE),
        .O_SYNC_FAILURE_FLAG(O_SYNC_FAILURE_FLAG),
        .O_INTERNAL_CLOCK_ACTIVE(O_INTERNAL_CLOCK_ACTIVE), .O_SKIP_ACTIVE(O_SKIP_ACTIVE)
    );

    // time in ns to whole core cycles, rounded up
    function automatic int cyc(input int ns);
        return (ns * 250 + 999) / 1000;
    endfunction : cyc

    // counts, verdict and end of run
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // cycles until the next rising edge of one gate
    task automatic rise(input int ph, output int c);
        logic p;
        c = 0;
        do begin
            p = O_GATE[ph];
            @(negedge I_CLK);
            c++;
            if (c > 1000) begin
                bad_count++;
                $display("Error gate rise expected within 1000 seen none");
                stop_test();
            end
        end while (!(p === 1'b0 && O_GATE[ph] === 1'b1));
    endtask : rise

    // high time of the next pulse, optionally tripping at its start
    task automatic width(input int ph, input logic trip, output int hw);
        int c;
        rise(ph, c);
        I_CURRENT_TRIP[ph] = trip;
        hw = 0;
        while (O_GATE[ph] === 1'b1 && hw < 1000) begin
            hw++;
            @(negedge I_CLK);
        end
        I_CURRENT_TRIP[ph] = 1'b0;
        if (hw >= 1000) begin
            bad_count++;
            $display("Error gate fall expected within 1000 seen none");
            stop_test();
        end
    endtask : width

    // new gate pulses seen over a number of cycles
    task automatic rises(input int lim, output int c);
        logic [1:0] p;
        c = 0;
        repeat (lim) begin
            p = O_GATE;
            @(negedge I_CLK);
            c += $countones(O_GATE & ~p);
        end
    endtask : rises

    // wait for a status output to reach a level
    task automatic wait_lvl(input int s, input logic lv, input int lim);
        logic v;
        for (int k = 0; k <= lim; k++) begin
            v = (s == 0) ? O_SYNC_FAILURE_FLAG : O_INTERNAL_CLOCK_ACTIVE;
            if (v === lv) return;
            @(negedge I_CLK);
        end
        bad_count++;
        $display("Error status %0d expected %0d seen timeout", s, lv);
        stop_test();
    endtask : wait_lvl

    // main sequence, inputs change on falling edges
    initial begin
        I_RST = 1'b1;
        I_CE = 1'b1;
        run = 1'b0;
        half_ns = 16'h0190;
        I_CURRENT_TRIP = 2'h0;
        I_PWM_CLOCK_SOURCE_SELECT = 2'h0;
        I_INTERNAL_PWM_FREQ_CODE = 5'h1b;
        I_SYNC_EDGE_INVERT = 1'b0;
        I_GATE_CLOCK_HALVING = 1'b0;
        I_PHASE_ENABLE_BITS = 2'h3;
        I_MIN_ON_TIME_CODE = 2'h0;
        I_MIN_OFF_TIME_CODE = 3'h0;
        I_SKIP_THRESHOLD_CODE = 2'h0;
        I_COMPENSATION_VOLTAGE = 8'hff;
        bad_count = 0;
        checked = 0;
        repeat (3) @(negedge I_CLK);
        `CHK("gate in reset", 0, O_GATE)
        I_RST = 1'b0;
        // source off with phases enabled
        repeat (3) @(negedge I_CLK);
        `CHK("fail when off", 1, O_SYNC_FAILURE_FLAG)
        rises(300, n);
        `CHK("pulses when off", 0, n)
        I_PHASE_ENABLE_BITS = 2'h0;
        repeat (3) @(negedge I_CLK);
        `CHK("fail when idle", 0, O_SYNC_FAILURE_FLAG)
        I_PHASE_ENABLE_BITS = 2'h3;
        // internal frequency, phase spacing and phase period
        I_PWM_CLOCK_SOURCE_SELECT = 2'h1;
        for (i = 0; i < 3; i++) begin
            I_INTERNAL_PWM_FREQ_CODE = 5'(fcode[i]);
            repeat (2) rise(0, n);
            rise(1, n);
            `CHK("internal spacing", fper[i], n)
            rise(0, n);
            rise(0, n);
            `CHK("phase period", 2 * fper[i], n)
        end
        I_INTERNAL_PWM_FREQ_CODE = 5'h1b;
        I_GATE_CLOCK_HALVING = 1'b1;
        repeat (2) rise(0, n);
        rise(1, n);
        `CHK("halved spacing", 250, n)
        I_GATE_CLOCK_HALVING = 1'b0;
        // minimum on-time with early trip, no pulse when tripped at start
        for (i = 0; i < 4; i++) begin
            I_MIN_ON_TIME_CODE = 2'(i);
            repeat (2) width(0, 1'b1, w);
            `CHK("min on", cyc(ton_ns[i]), w)
        end
        I_CURRENT_TRIP = 2'h3;
        repeat (3) @(negedge I_CLK);
        rises(300, n);
        `CHK("pulses tripped", 0, n)
        I_CURRENT_TRIP = 2'h0;
        // light load skips pulses below each threshold
        for (i = 0; i < 4; i++) begin
            I_SKIP_THRESHOLD_CODE = 2'(i);
            I_COMPENSATION_VOLTAGE = 8'(thr[i] - 1);
            repeat (3) @(negedge I_CLK);
            `CHK("skip set", 1, O_SKIP_ACTIVE)
            rises(300, n);
            `CHK("pulses skipped", 0, n)
            I_COMPENSATION_VOLTAGE = 8'(thr[i]);
            repeat (3) @(negedge I_CLK);
            `CHK("skip clear", 0, O_SKIP_ACTIVE)
        end
        I_COMPENSATION_VOLTAGE = 8'hff;
        // external clock, maximum on-time per off-time code
        run = 1'b1;
        I_PWM_CLOCK_SOURCE_SELECT = 2'h2;
        for (i = 0; i < 8; i++) begin
            I_MIN_OFF_TIME_CODE = 3'(i);
            repeat (3) width(0, 1'b0, w);
            `CHK("max on", 400 - cyc(toff_ns[i]), w)
        end
        rise(0, n);
        rise(1, n);
        `CHK("external spacing", 200, n)
        `CHK("fail with sync", 0, O_SYNC_FAILURE_FLAG)
        // sync edge polarity
        for (i = 0; i < 2; i++) begin
            I_SYNC_EDGE_INVERT = 1'(i);
            repeat (3) rise(0, n);
            `CHK("pin at start", 1 - i, I_SYNC_PIN)
        end
        I_SYNC_EDGE_INVERT = 1'b0;
        // automatic choice, fallback and return
        I_PWM_CLOCK_SOURCE_SELECT = 2'h3;
        repeat (600) @(negedge I_CLK);
        `CHK("auto on external", 0, O_INTERNAL_CLOCK_ACTIVE)
        run = 1'b0;
        wait_lvl(1, 1'b1, 600);
        repeat (2) @(negedge I_CLK);
        `CHK("fail auto lost", 1, O_SYNC_FAILURE_FLAG)
        rises(300, n);
        `CHK("pulses on fallback", 1, n > 0)
        run = 1'b1;
        wait_lvl(1, 1'b0, 200);
        repeat (2) @(negedge I_CLK);
        `CHK("fail auto back", 0, O_SYNC_FAILURE_FLAG)
        // external only, sync lost
        I_PWM_CLOCK_SOURCE_SELECT = 2'h2;
        run = 1'b0;
        wait_lvl(0, 1'b1, 600);
        `CHK("no fallback ext", 0, O_INTERNAL_CLOCK_ACTIVE)
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
